// ### src/track_sup_map.svh
// register offsets, field positions, reset values and timing counts of the tracking supervisor
`ifndef TRACK_SUP_MAP_SVH
`define TRACK_SUP_MAP_SVH
`define ADDR_CTRL 8'h00
`define ADDR_VOUT_CMD 8'h04
`define ADDR_OV_LIMIT 8'h08
`define ADDR_IRQ_STATUS 8'h0C
`define ADDR_IRQ_MASK 8'h10
`define ADDR_STATE 8'h14
`define ADDR_TARGET 8'h18
`define ADDR_OV_ACTIVE 8'h1C
`define ADDR_TON_DELAY 8'h20
`define ADDR_TON_RISE 8'h24
`define ADDR_TOFF_DELAY 8'h28
`define ADDR_TOFF_FALL 8'h2C
`define CTRL_ENABLE_BIT 0
`define CTRL_SOFTSTOP_BIT 1
`define EVT_CAL_DONE_BIT 0
`define EVT_PG_RISE_BIT 1
`define EVT_PG_FALL_BIT 2
`define EVT_WIDTH 3
`define STRAP_TRACK_MAX_OHM 16'h107C
`define VOUT_DEFAULT_MV 16'h1482
`define MEAS_FLOOR_MV 16'h01C2
`define MEAS_WINDOW_MV 16'h0064
`define BAND_EDGE_0_MV 16'h03DE
`define BAND_EDGE_1_MV 16'h0460
`define BAND_EDGE_2_MV 16'h0500
`define BAND_EDGE_3_MV 16'h05DC
`define BAND_EDGE_4_MV 16'h071C
`define BAND_EDGE_5_MV 16'h08F2
`define BAND_EDGE_6_MV 16'h0C30
`define RECIP_BAND_0 16'h1013
`define RECIP_BAND_1 16'h1223
`define RECIP_BAND_2 16'h14CF
`define RECIP_BAND_3 16'h1867
`define RECIP_BAND_4 16'h1D7F
`define RECIP_BAND_5 16'h2547
`define RECIP_BAND_6 16'h32A3
`define RECIP_BAND_7 16'h4EED
`define RECIP_FRAC_BITS 12
`define OV_TRACK_GAIN 16'h047B
`define OV_NORMAL_GAIN 16'h049A
`define OV_GAIN_FRAC_BITS 10
`define TON_DELAY_MIN 16'h0000
`define TON_RISE_MIN 16'h0000
`define MEAS_INTERVAL_MS 10
`define CLK_RATE_KHZ 40000
`endif

// ### src/track_sup_pkg.sv
// types shared by the tracking supervisor
package track_sup_pkg;
  typedef enum logic [2:0] {ST_INIT, ST_IDLE, ST_QUAL, ST_CAL, ST_GOOD} qual_state_type;
  typedef enum logic [1:0] {OFF_RUN, OFF_DELAY, OFF_FALL, OFF_DONE} stop_state_type;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wrData;
    logic wrStrobe;
    logic rdStrobe;
  } reg_req_type;
  typedef struct packed {
    logic [15:0] voutMv;
    logic [15:0] trackSenseMv;
    logic [15:0] strapOhm;
    logic strapValid;
  } meas_type;
  typedef struct packed {
    logic [15:0] tonDelay;
    logic [15:0] tonRise;
    logic uvFaultEnable;
    logic [15:0] ovLimitMv;
  } prot_type;
endpackage

// ### src/output_voltage_tracking_supervisor.sv
// tracking-mode supervisor: strap capture, feedback band, target, calibration, power good
// Function
// - tracking mode when strap at most 4.22 kilohm
// - regulate to lower of tracked and commanded
// - feedback ratio picked from eight command bands
// - undefined command defaults 5.25 V, lowest ratio
// - feedback ratio fixed at power-up only
// - calibrate after two stable samples 10 ms apart
// - in tracking mode, power good only after calibration completes
// - power good drops on 10 ms check at or below 450 mV
// - tracking over-voltage limit 12% above command
// - host may override tracking over-voltage limit
// - under-voltage detection off in tracking mode
// - tracking forces turn-on delay and rise minimum
// - soft-stop ramp limited by tracking level
// - strap measured once during power-up
// - power good is active-high open drain
`timescale 1ns/10ps
`default_nettype none
`include "track_sup_map.svh"
module output_voltage_tracking_supervisor
#(
  parameter int INTERVAL_CYCLES = `CLK_RATE_KHZ * `MEAS_INTERVAL_MS
)
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire track_sup_pkg::reg_req_type regReq,
  output logic [31:0] rdData,
  input wire track_sup_pkg::meas_type meas,
  input wire logic [15:0] nvmVoutCmdMv,
  input wire logic nvmVoutCmdDefined,
  input wire logic calDone,
  input wire logic normalPowerGood,
  input wire logic powerGoodOutputIn,
  output logic powerGoodOutputOut,
  output logic powerGoodOutputOeN,
  output logic calStart,
  output logic trackMode,
  output logic [2:0] feedbackBand,
  output logic [15:0] regTargetMv,
  output track_sup_pkg::prot_type prot,
  output logic irq
);
  import track_sup_pkg::*;

  localparam logic [31:0] INTERVAL_LAST = 32'(INTERVAL_CYCLES - 1);

  typedef struct packed {
    qual_state_type qual;
    stop_state_type stop;
    logic [31:0] timer;
    logic tick;
    logic trackMode;
    logic [2:0] band;
    logic [15:0] voutCmd;
    logic cmdDefined;
    logic [15:0] ovUser;
    logic ovOverride;
    logic enable;
    logic softStop;
    logic [15:0] tonDelay;
    logic [15:0] tonRise;
    logic [15:0] toffDelay;
    logic [15:0] toffFall;
    logic [15:0] prevMv;
    logic powerGood;
    logic calStart;
    logic [15:0] stopCount;
    logic [15:0] rampMv;
    logic [15:0] target;
    logic [15:0] ovActive;
    logic [`EVT_WIDTH-1:0] status;
    logic [`EVT_WIDTH-1:0] mask;
    logic irq;
    logic [31:0] rdData;
    logic pgSync1;
    logic pgSync2;
  } state_type;

  state_type cur_ff;
  state_type nxt_cur;

  // band index from a command level, highest band for the largest targets
  function automatic logic [2:0] bandOf(input logic [15:0] mv);
    logic [2:0] b;
    b = 3'h7;
    if (mv < `BAND_EDGE_0_MV) b = 3'h0;
    else if (mv < `BAND_EDGE_1_MV) b = 3'h1;
    else if (mv < `BAND_EDGE_2_MV) b = 3'h2;
    else if (mv < `BAND_EDGE_3_MV) b = 3'h3;
    else if (mv < `BAND_EDGE_4_MV) b = 3'h4;
    else if (mv < `BAND_EDGE_5_MV) b = 3'h5;
    else if (mv < `BAND_EDGE_6_MV) b = 3'h6;
    return b;
  endfunction

  // reciprocal of the feedback ratio, fixed point
  function automatic logic [15:0] recipOf(input logic [2:0] b);
    logic [15:0] r;
    case (b)
      3'h0: r = `RECIP_BAND_0;
      3'h1: r = `RECIP_BAND_1;
      3'h2: r = `RECIP_BAND_2;
      3'h3: r = `RECIP_BAND_3;
      3'h4: r = `RECIP_BAND_4;
      3'h5: r = `RECIP_BAND_5;
      3'h6: r = `RECIP_BAND_6;
      default: r = `RECIP_BAND_7;
    endcase
    return r;
  endfunction

  function automatic logic [15:0] minOf(input logic [15:0] a, input logic [15:0] b);
    return (a < b) ? a : b;
  endfunction

  function automatic logic [15:0] sat16(input logic [31:0] v);
    return (v[31:16] != 16'h0000) ? 16'hFFFF : v[15:0];
  endfunction

  logic [31:0] trackProd;
  logic [15:0] trackLevel;
  logic [31:0] ovProd;
  logic [15:0] diffMv;
  logic aboveFloor;
  logic inWindow;
  logic [`EVT_WIDTH-1:0] events;

  always_comb
  begin
    nxt_cur = cur_ff;
    events = '0;
    trackProd = 32'(meas.trackSenseMv) * 32'(recipOf(cur_ff.band));
    trackLevel = sat16(trackProd >> `RECIP_FRAC_BITS);
    ovProd = 32'(cur_ff.voutCmd) * 32'(cur_ff.trackMode ? `OV_TRACK_GAIN : `OV_NORMAL_GAIN);
    diffMv = (meas.voutMv > cur_ff.prevMv) ? (meas.voutMv - cur_ff.prevMv)
                                            : (cur_ff.prevMv - meas.voutMv);
    aboveFloor = meas.voutMv > `MEAS_FLOOR_MV;
    inWindow = diffMv <= `MEAS_WINDOW_MV;
    nxt_cur.pgSync1 = powerGoodOutputIn;
    nxt_cur.pgSync2 = cur_ff.pgSync1;
    nxt_cur.calStart = 1'b0;
    // free-running measurement interval
    nxt_cur.tick = (cur_ff.timer == INTERVAL_LAST);
    nxt_cur.timer = nxt_cur.tick ? 32'h0000_0000 : cur_ff.timer + 32'h0000_0001;
    nxt_cur.ovActive = (cur_ff.trackMode && cur_ff.ovOverride) ? cur_ff.ovUser
                     : sat16(ovProd >> `OV_GAIN_FRAC_BITS);
    // soft-stop sequencing, in measurement intervals
    case (cur_ff.stop)
      OFF_RUN:
      begin
        nxt_cur.rampMv = cur_ff.target;
        if (!cur_ff.enable)
        begin
          nxt_cur.stop = cur_ff.softStop ? OFF_DELAY : OFF_DONE;
          nxt_cur.stopCount = cur_ff.toffDelay;
        end
      end
      OFF_DELAY:
        if (cur_ff.tick)
        begin
          if (cur_ff.stopCount == 16'h0000) nxt_cur.stop = OFF_FALL;
          else nxt_cur.stopCount = cur_ff.stopCount - 16'h0001;
        end
      OFF_FALL:
        if (cur_ff.tick)
        begin
          if (cur_ff.rampMv <= cur_ff.toffFall) nxt_cur.stop = OFF_DONE;
          else nxt_cur.rampMv = cur_ff.rampMv - cur_ff.toffFall;
        end
      default:
        if (cur_ff.enable) nxt_cur.stop = OFF_RUN;
    endcase
    if (cur_ff.enable && cur_ff.stop != OFF_RUN) nxt_cur.stop = OFF_RUN;
    // regulation target
    if (cur_ff.stop == OFF_RUN && cur_ff.enable)
      nxt_cur.target = cur_ff.trackMode ? minOf(trackLevel, cur_ff.voutCmd)
                                        : cur_ff.voutCmd;
    else if (cur_ff.stop == OFF_DELAY || cur_ff.stop == OFF_FALL
             || (cur_ff.stop == OFF_RUN && cur_ff.softStop))
      nxt_cur.target = cur_ff.trackMode ? minOf(minOf(trackLevel, cur_ff.voutCmd),
                                                cur_ff.rampMv)
                                        : cur_ff.rampMv;
    else
      nxt_cur.target = 16'h0000;
    // calibration qualification and power good
    case (cur_ff.qual)
      ST_INIT:
        if (meas.strapValid)
        begin
          nxt_cur.trackMode = meas.strapOhm <= `STRAP_TRACK_MAX_OHM;
          nxt_cur.voutCmd = nvmVoutCmdDefined ? nvmVoutCmdMv : `VOUT_DEFAULT_MV;
          nxt_cur.cmdDefined = nvmVoutCmdDefined;
          nxt_cur.band = nvmVoutCmdDefined ? bandOf(nvmVoutCmdMv) : 3'h7;
          nxt_cur.qual = ST_IDLE;
        end
      ST_IDLE:
        if (cur_ff.trackMode && cur_ff.enable && cur_ff.tick && aboveFloor)
        begin
          nxt_cur.prevMv = meas.voutMv;
          nxt_cur.qual = ST_QUAL;
        end
      ST_QUAL:
        if (cur_ff.tick)
        begin
          if (!aboveFloor) nxt_cur.qual = ST_IDLE;
          else if (inWindow)
          begin
            nxt_cur.calStart = 1'b1;
            nxt_cur.qual = ST_CAL;
          end
          else nxt_cur.prevMv = meas.voutMv;
        end
      ST_CAL:
        if (calDone)
        begin
          nxt_cur.qual = ST_GOOD;
          events[`EVT_CAL_DONE_BIT] = 1'b1;
        end
      ST_GOOD:
        if (cur_ff.tick && !aboveFloor) nxt_cur.qual = ST_IDLE;
      default:
        nxt_cur.qual = ST_IDLE;
    endcase
    if (cur_ff.qual != ST_INIT && (!cur_ff.enable || !cur_ff.trackMode))
      nxt_cur.qual = ST_IDLE;
    nxt_cur.powerGood = cur_ff.trackMode ? (nxt_cur.qual == ST_GOOD)
                                         : (cur_ff.enable && normalPowerGood);
    events[`EVT_PG_RISE_BIT] = nxt_cur.powerGood && !cur_ff.powerGood;
    events[`EVT_PG_FALL_BIT] = !nxt_cur.powerGood && cur_ff.powerGood;
    // register writes; a band change needs a power cycle to take effect
    if (regReq.wrStrobe)
      case (regReq.addr)
        `ADDR_CTRL:
        begin
          nxt_cur.enable = regReq.wrData[`CTRL_ENABLE_BIT];
          nxt_cur.softStop = regReq.wrData[`CTRL_SOFTSTOP_BIT];
        end
        `ADDR_VOUT_CMD:
        begin
          nxt_cur.voutCmd = regReq.wrData[15:0];
          nxt_cur.cmdDefined = 1'b1;
        end
        `ADDR_OV_LIMIT:
        begin
          nxt_cur.ovUser = regReq.wrData[15:0];
          nxt_cur.ovOverride = 1'b1;
        end
        `ADDR_IRQ_MASK: nxt_cur.mask = regReq.wrData[`EVT_WIDTH-1:0];
        `ADDR_TON_DELAY: nxt_cur.tonDelay = regReq.wrData[15:0];
        `ADDR_TON_RISE: nxt_cur.tonRise = regReq.wrData[15:0];
        `ADDR_TOFF_DELAY: nxt_cur.toffDelay = regReq.wrData[15:0];
        `ADDR_TOFF_FALL: nxt_cur.toffFall = regReq.wrData[15:0];
        default: ;
      endcase
    // sticky events: a new event wins over a write-one clear
    if (regReq.wrStrobe && regReq.addr == `ADDR_IRQ_STATUS)
      nxt_cur.status = (cur_ff.status & ~regReq.wrData[`EVT_WIDTH-1:0]) | events;
    else
      nxt_cur.status = cur_ff.status | events;
    nxt_cur.irq = |(nxt_cur.status & nxt_cur.mask);
    nxt_cur.rdData = 32'h0000_0000;
    if (regReq.rdStrobe)
      case (regReq.addr)
        `ADDR_CTRL: nxt_cur.rdData = {30'h0, cur_ff.softStop, cur_ff.enable};
        `ADDR_VOUT_CMD: nxt_cur.rdData = {15'h0, cur_ff.cmdDefined, cur_ff.voutCmd};
        `ADDR_OV_LIMIT: nxt_cur.rdData = {15'h0, cur_ff.ovOverride, cur_ff.ovUser};
        `ADDR_IRQ_STATUS: nxt_cur.rdData = {29'h0, cur_ff.status};
        `ADDR_IRQ_MASK: nxt_cur.rdData = {29'h0, cur_ff.mask};
        `ADDR_STATE: nxt_cur.rdData = {20'h0, cur_ff.pgSync2, cur_ff.powerGood,
                                       cur_ff.stop, 1'b0, cur_ff.qual,
                                       cur_ff.band, cur_ff.trackMode};
        `ADDR_TARGET: nxt_cur.rdData = {16'h0, cur_ff.target};
        `ADDR_OV_ACTIVE: nxt_cur.rdData = {16'h0, cur_ff.ovActive};
        `ADDR_TON_DELAY: nxt_cur.rdData = {16'h0, cur_ff.tonDelay};
        `ADDR_TON_RISE: nxt_cur.rdData = {16'h0, cur_ff.tonRise};
        `ADDR_TOFF_DELAY: nxt_cur.rdData = {16'h0, cur_ff.toffDelay};
        `ADDR_TOFF_FALL: nxt_cur.rdData = {16'h0, cur_ff.toffFall};
        default: nxt_cur.rdData = 32'h0000_0000;
      endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      cur_ff <= '0;
      cur_ff.qual <= ST_INIT;
      cur_ff.stop <= OFF_DONE;
      cur_ff.band <= 3'h7;
      cur_ff.voutCmd <= `VOUT_DEFAULT_MV;
    end
    else
      cur_ff <= nxt_cur;
  end

  // protection and start-up parameters seen by the power stage
  prot_type nxt_prot;
  prot_type prot_ff;
  always_comb
  begin
    nxt_prot.ovLimitMv = cur_ff.ovActive;
    nxt_prot.uvFaultEnable = !cur_ff.trackMode;
    nxt_prot.tonDelay = cur_ff.trackMode ? `TON_DELAY_MIN : cur_ff.tonDelay;
    nxt_prot.tonRise = cur_ff.trackMode ? `TON_RISE_MIN : cur_ff.tonRise;
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      prot_ff <= '0;
    else
      prot_ff <= nxt_prot;
  end

  assign prot = prot_ff;
  assign rdData = cur_ff.rdData;
  // open drain: pin pulled low (enable low) unless power is good
  assign powerGoodOutputOut = 1'b0;
  assign powerGoodOutputOeN = cur_ff.powerGood;
  assign calStart = cur_ff.calStart;
  assign trackMode = cur_ff.trackMode;
  assign feedbackBand = cur_ff.band;
  assign regTargetMv = cur_ff.target;
  assign irq = cur_ff.irq;
endmodule
`default_nettype wire

// ### bench/track_sup_properties.sv
// concurrent checks on the tracking supervisor ports
`timescale 1ns/10ps
`default_nettype none
`include "track_sup_map.svh"
module track_sup_properties
#(
  parameter int INTERVAL_CYCLES = 20
)
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire track_sup_pkg::meas_type meas,
  input wire logic calDone,
  input wire logic powerGoodOutputOut,
  input wire logic powerGoodOutputOeN,
  input wire logic calStart,
  input wire logic trackMode,
  input wire logic [2:0] feedbackBand,
  input wire track_sup_pkg::prot_type prot
);
  import track_sup_pkg::*;
  localparam logic [15:0] STRAP_MAX = 16'h107C;
  int lowCnt;
  // cycles the output has sat at or below the floor while tracking
  always_ff @(posedge clk_sys)
    if (srst || !trackMode || meas.voutMv > `MEAS_FLOOR_MV)
      lowCnt <= 0;
    else
      lowCnt <= lowCnt + 1;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);
  sequence s_settled;
    trackMode && $past(trackMode) && $past(trackMode, 2);
  endsequence
  sequence s_pulse;
    trackMode ##1 !calStart;
  endsequence
  property p_pin_low;
    powerGoodOutputOut == 1'b0;
  endproperty
  a_pin_low: assert property (p_pin_low) else $error("pg pin driven high");
  property p_track_strap;
    $rose(trackMode) |-> $past(meas.strapValid) && $past(meas.strapOhm) <= STRAP_MAX;
  endproperty
  a_track_strap: assert property (p_track_strap) else $error("bad mode entry");
  property p_mode_once;
    $changed(trackMode) |-> $past(meas.strapValid);
  endproperty
  a_mode_once: assert property (p_mode_once) else $error("mode moved");
  property p_band_once;
    $changed(feedbackBand) |-> $past(meas.strapValid);
  endproperty
  a_band_once: assert property (p_band_once) else $error("band moved");
  property p_uv_off;
    s_settled |-> !prot.uvFaultEnable;
  endproperty
  a_uv_off: assert property (p_uv_off) else $error("uv enabled");
  property p_ton_min;
    s_settled |-> prot.tonDelay == `TON_DELAY_MIN && prot.tonRise == `TON_RISE_MIN;
  endproperty
  a_ton_min: assert property (p_ton_min) else $error("turn-on not minimum");
  property p_cal_pulse;
    calStart |-> s_pulse;
  endproperty
  a_cal_pulse: assert property (p_cal_pulse) else $error("bad cal start");
  property p_pg_after_cal;
    trackMode && $rose(powerGoodOutputOeN) |-> $past(calDone);
  endproperty
  a_pg_after_cal: assert property (p_pg_after_cal) else $error("early pg");
  property p_pg_drop;
    lowCnt > INTERVAL_CYCLES + 2 |-> !powerGoodOutputOeN;
  endproperty
  a_pg_drop: assert property (p_pg_drop) else $error("pg held low output");
endmodule
`default_nettype wire

// ### bench/master_supply_model.sv
// master supply feeding the tracking sense input
`timescale 1ns/10ps
`default_nettype none
module master_supply_model
(
  input wire logic clk_sys,
  input wire logic [15:0] goalMv,
  input wire logic slow,
  output var logic [15:0] senseMv
);
  initial senseMv = 16'h0000;
  // slow mode ramps up 8 mV a cycle like a soft-started master
  always @(posedge clk_sys)
    if (slow && senseMv + 16'h0008 < goalMv)
      senseMv <= senseMv + 16'h0008;
    else
      senseMv <= goalMv;
endmodule
`default_nettype wire

// ### bench/output_voltage_tracking_supervisor_bench.sv
// self-checking bench of the tracking supervisor
`timescale 1ns/10ps
`default_nettype none
`include "track_sup_map.svh"
module output_voltage_tracking_supervisor_bench;
  import track_sup_pkg::*;
  localparam int IC = 20;
  localparam logic [15:0] EDGES [7] = '{`BAND_EDGE_0_MV, `BAND_EDGE_1_MV, `BAND_EDGE_2_MV,
    `BAND_EDGE_3_MV, `BAND_EDGE_4_MV, `BAND_EDGE_5_MV, `BAND_EDGE_6_MV};
  localparam logic [15:0] CMDS [8] = '{16'h0384, 16'h03DE, 16'h04B0, 16'h0578, 16'h0640,
    16'h07D0, 16'h09C4, 16'h0C30};
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  reg_req_type regReq = '0;
  logic [15:0] voutMv = 16'h0000;
  logic [15:0] strapOhm = 16'h0000;
  logic strapValid = 1'b0;
  logic [15:0] nvmCmd = 16'h0000;
  logic nvmDef = 1'b0;
  logic calDone = 1'b0;
  logic normalPg = 1'b0;
  logic [15:0] goalMv = 16'h0000;
  logic slow = 1'b0;
  logic [31:0] lfsr = 32'h0000_6BCC;
  logic [31:0] rdData, d;
  logic pgOut, pgOeN, calStart, trackMode, irq;
  logic [2:0] feedbackBand;
  logic [15:0] regTargetMv, senseMv, ohm, cmd;
  prot_type prot;
  int failures = 0;
  int compares = 0;
  int calCount = 0;
  int n0, k;
  wire logic pgPin = pgOeN ? 1'b1 : pgOut;
  always #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
    if (calStart === 1'b1)
      calCount <= calCount + 1;
  master_supply_model sup_u (.clk_sys(clk_sys), .goalMv(goalMv), .slow(slow),
    .senseMv(senseMv));
  output_voltage_tracking_supervisor #(.INTERVAL_CYCLES(IC)) dut_u (.clk_sys(clk_sys),
    .srst(srst), .regReq(regReq), .rdData(rdData),
    .meas({voutMv, senseMv, strapOhm, strapValid}), .nvmVoutCmdMv(nvmCmd),
    .nvmVoutCmdDefined(nvmDef), .calDone(calDone), .normalPowerGood(normalPg),
    .powerGoodOutputIn(pgPin), .powerGoodOutputOut(pgOut), .powerGoodOutputOeN(pgOeN),
    .calStart(calStart), .trackMode(trackMode), .feedbackBand(feedbackBand),
    .regTargetMv(regTargetMv), .prot(prot), .irq(irq));
  function automatic logic [31:0] nextRand(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h0040_0007 : 32'h0000_0000);
  endfunction
  function automatic logic [2:0] expBand(input logic [15:0] mv);
    logic [2:0] b;
    b = 3'h0;
    foreach (EDGES[i])
      if (mv >= EDGES[i])
        b = b + 3'h1;
    return b;
  endfunction
  task automatic conclude();
    if (failures == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    regReq <= '{a, v, 1'b1, 1'b0};
    @(posedge clk_sys);
    regReq.wrStrobe <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_sys);
    regReq <= '{a, 32'h0000_0000, 1'b0, 1'b1};
    @(posedge clk_sys);
    regReq.rdStrobe <= 1'b0;
    #1 v = rdData;
  endtask
  task automatic powerUp(input logic [15:0] o, input logic [15:0] c, input logic df);
    @(posedge clk_sys);
    srst <= 1'b1;
    nvmCmd <= c;
    nvmDef <= df;
    regReq <= '0;
    tick(5);
    srst <= 1'b0;
    strapOhm <= o;
    strapValid <= 1'b1;
    @(posedge clk_sys);
    strapValid <= 1'b0;
    wr(`ADDR_CTRL, 32'h0000_0001);
    tick(3);
  endtask
  initial
  begin
    for (int i = 0; i < 12; i++)
    begin
      lfsr = nextRand(lfsr);
      ohm = (i == 8) ? 16'h107D : (i < 8) ? 16'h107C - 16'(i) : {3'h0, lfsr[28:16]};
      cmd = (i < 8) ? CMDS[i] : 16'h0258 + 16'(lfsr[15:0] % 16'h122A);
      normalPg <= lfsr[0];
      goalMv <= {5'h00, lfsr[10:0]};
      powerUp(ohm, cmd, 1'b1);
      chk("trackMode", 32'(ohm <= 16'h107C), 32'(trackMode));
      if (ohm <= 16'h107C)
      begin
        chk("band", 32'(expBand(cmd)), 32'(feedbackBand));
        wr(`ADDR_VOUT_CMD, (expBand(cmd) == 3'h7) ? 32'h0000_0300 : 32'h0000_1000);
        tick(2);
        chk("bandKept", 32'(expBand(cmd)), 32'(feedbackBand));
      end
      else
        chk("pgNormal", 32'(normalPg), 32'(pgOeN));
    end
    goalMv <= 16'h04B0;
    powerUp(16'h0000, 16'h0400, 1'b0);
    chk("defBand", 32'h0000_0007, 32'(feedbackBand));
    chk("defTarget", 32'(`VOUT_DEFAULT_MV), 32'(regTargetMv));
    goalMv <= 16'h0000;
    powerUp(16'h0000, 16'h0400, 1'b1);
    chk("targetLow", 32'h0000_0000, 32'(regTargetMv));
    slow <= 1'b1;
    goalMv <= 16'h04B0;
    tick(160);
    chk("targetHigh", 32'h0000_0400, 32'(regTargetMv));
    chk("ovTrack", 32'h0000_047B, 32'(prot.ovLimitMv));
    wr(`ADDR_TON_DELAY, 32'h0000_0005);
    wr(`ADDR_TON_RISE, 32'h0000_0007);
    wr(`ADDR_OV_LIMIT, 32'h0000_0500);
    tick(3);
    chk("tonDelay", 32'h0000_0000, 32'(prot.tonDelay));
    chk("ovOver", 32'h0000_0500, 32'(prot.ovLimitMv));
    rd(8'h40, d);
    chk("unmapped", 32'h0000_0000, d);
    rd(`ADDR_STATE, d);
    chk("stateTrack", 32'h0000_0001, 32'(d[0]));
    wr(`ADDR_IRQ_MASK, 32'h0000_0001);
    n0 = calCount;
    for (k = 0; k < 3 * IC; k++)
    begin
      @(posedge clk_sys);
      voutMv <= (k < IC) ? 16'h0190 : 16'h03E8 + 16'h00C8 * 16'(k % 3);
    end
    chk("noCal", 32'(n0), 32'(calCount));
    @(posedge clk_sys);
    voutMv <= 16'h03E8;
    k = 0;
    while (calStart !== 1'b1 && k < 4 * IC)
    begin
      @(posedge clk_sys);
      #1;
      k++;
    end
    chk("calStart", 32'h0000_0001, 32'(calStart));
    chk("pgEarly", 32'h0000_0000, 32'(pgOeN));
    @(posedge clk_sys);
    calDone <= 1'b1;
    @(posedge clk_sys);
    calDone <= 1'b0;
    tick(1);
    chk("pgUp", 32'h0000_0001, 32'(pgOeN));
    chk("irqCal", 32'h0000_0001, 32'(irq));
    wr(`ADDR_IRQ_STATUS, 32'h0000_0001);
    tick(2);
    chk("irqClr", 32'h0000_0000, 32'(irq));
    @(posedge clk_sys);
    voutMv <= 16'h0190;
    k = 0;
    while (pgOeN !== 1'b0 && k < IC + 4)
    begin
      @(posedge clk_sys);
      #1;
      k++;
    end
    chk("pgDrop", 32'h0000_0000, 32'(pgOeN));
    // soft stop from a 1024 mV target, then pull the master down to 400 mV
    wr(`ADDR_TOFF_DELAY, 32'h0000_0001);
    wr(`ADDR_TOFF_FALL, 32'h0000_0100);
    wr(`ADDR_CTRL, 32'h0000_0002);
    goalMv <= 16'h0190;
    tick(3);
    chk("stopTrack", (32'h0000_0190 * 32'(`RECIP_BAND_1)) >> `RECIP_FRAC_BITS,
      32'(regTargetMv));
    k = 0;
    while (regTargetMv >= 16'h01C5 && k < 8 * IC)
    begin
      @(posedge clk_sys);
      #1;
      k++;
    end
    chk("stopRamp", 32'h0000_0100, 32'(regTargetMv));
    tick(IC + 2);
    chk("stopDone", 32'h0000_0000, 32'(regTargetMv));
    conclude();
  end
  initial
  begin
    tick(4000);
    failures++;
    conclude();
  end
endmodule
bind output_voltage_tracking_supervisor track_sup_properties
  #(.INTERVAL_CYCLES(INTERVAL_CYCLES)) chk_u (.clk_sys(clk_sys), .srst(srst), .meas(meas),
  .calDone(calDone), .powerGoodOutputOut(powerGoodOutputOut),
  .powerGoodOutputOeN(powerGoodOutputOeN), .calStart(calStart), .trackMode(trackMode),
  .feedbackBand(feedbackBand), .prot(prot));
`default_nettype wire
